/* design/usbcs_pkg.sv */
package usbcs_pkg;
    localparam logic [7:0] ADDR_CONTROL   = 8'h05;
    localparam logic [7:0] ADDR_INT_EN    = 8'h06;
    localparam logic [7:0] ADDR_DEV_ADDR  = 8'h07;
    localparam logic [7:0] ADDR_INT_STAT  = 8'h0d;
    localparam logic [7:0] ADDR_DATA_SET  = 8'h0e;
    localparam logic [7:0] ADDR_FRAME_LO  = 8'h15;
    localparam logic [7:0] ADDR_FRAME_HI  = 8'h16;
    localparam logic [7:0] ADDR_DMA_LO    = 8'h35;
    localparam logic [7:0] ADDR_DMA_HI    = 8'h36;

    localparam int CTL_USB_EN   = 0;
    localparam int CTL_DMA_EN   = 1;
    localparam int CTL_DMA_DIR  = 2;
    localparam int CTL_FORCE_LO = 3;
    localparam int CTL_FORCE_HI = 4;
    localparam int CTL_SPEED    = 5;
    localparam int CTL_STBY     = 6;
    localparam int INT_DMA_BUSY = 7;
    localparam int EV_DMA_DONE  = 4;
    localparam int EV_SOF       = 5;
    localparam int EV_BUS_RESET = 6;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h7f;
    localparam logic [6:0] EVENT_MASK    = 7'h7f;
    localparam logic [7:0] ZERO8         = 8'h00;

    typedef enum logic [1:0] {
        USBCS_FORCE_NORMAL,
        USBCS_FORCE_SE0,
        USBCS_FORCE_K,
        USBCS_FORCE_J
    } usbcs_force_t;
endpackage

/* design/usbcs_regs.sv */
`timescale 1ns/1ps
module usbcs_regs
    import usbcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    // 8-bit host port, strobes active low, a0 low selects the pointer
    input  wire logic        csN,
    input  wire logic        rdN,
    input  wire logic        wrN,
    input  wire logic        a0,
    input  wire logic [7:0]  dataIn,
    output logic      [7:0]  dataOut,
    output logic             dataOeN,
    output logic             interrupt_request_out,
    // usb engine side, same clock
    input  wire logic [3:0]  epDone,
    input  wire logic        dmaDone,
    input  wire logic        sofReceived,
    input  wire logic [10:0] sofFrame,
    input  wire logic        busResetSeen,
    input  wire logic [3:0]  dataSetSel,
    input  wire logic        tokenValid,
    input  wire logic [6:0]  tokenAddr,
    input  wire logic [3:0]  tokenEndpoint,
    output logic             tokenAccept,
    output logic             transferEnable,
    output logic             dmaEnable,
    output logic             dmaReadDir,
    output logic             dmaStart,
    output logic      [15:0] dmaTotalCount,
    output logic      [1:0]  lineForce,
    output logic             bus_speed_select,
    output logic             transceiver_standby,
    output logic             suspendMode
);
    logic [2:0]  pinS;
    logic        csNs;
    logic        rdNs;
    logic        wrNs;
    logic        wrPrevQ;
    logic        rdPrevQ;
    logic        wrPulse;
    logic        rdPulse;
    logic [7:0]  pointerQ;
    logic [7:0]  controlQ;
    logic [6:0]  intEnQ;
    logic [6:0]  intStatQ;
    logic        dmaBusyQ;
    logic [7:0]  devAddrQ;
    logic [6:0]  frameLoQ;
    logic [3:0]  frameHiQ;
    logic [7:0]  dmaLoQ;
    logic [7:0]  dmaHiQ;
    logic [6:0]  events;
    logic [7:0]  readData;

    usbcs_sync #(.WIDTH(3)) strobeSync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({csN, rdN, wrN}),
        .dout   (pinS)
    );
    assign csNs = pinS[2];
    assign rdNs = pinS[1];
    assign wrNs = pinS[0];

    function automatic logic isData(input logic sel);
        return sel;
    endfunction

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPrevQ <= 1'b0;
            rdPrevQ <= 1'b0;
        end else begin
            wrPrevQ <= !csNs && !wrNs;
            rdPrevQ <= !csNs && !rdNs;
        end
    end
    // data and a0 are steady on the first cycle of the synchronised strobe
    assign wrPulse = !csNs && !wrNs && !wrPrevQ;
    assign rdPulse = !rdPrevQ && !csNs && !rdNs;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pointerQ <= ZERO8;
        end else if (wrPulse && !isData(a0)) begin
            pointerQ <= dataIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            controlQ <= CONTROL_RESET;
        end else if (wrPulse && isData(a0) && pointerQ == ADDR_CONTROL) begin
            controlQ <= dataIn & CONTROL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            intEnQ <= '0;
        end else if (wrPulse && isData(a0) && pointerQ == ADDR_INT_EN) begin
            intEnQ <= dataIn[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            devAddrQ <= ZERO8;
        end else if (wrPulse && isData(a0) && pointerQ == ADDR_DEV_ADDR) begin
            devAddrQ <= dataIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dmaLoQ <= ZERO8;
            dmaHiQ <= ZERO8;
        end else if (wrPulse && isData(a0)) begin
            if (pointerQ == ADDR_DMA_LO) begin
                dmaLoQ <= dataIn;
            end
            if (pointerQ == ADDR_DMA_HI) begin
                dmaHiQ <= dataIn;
            end
        end
    end

    // dma starts only on a count high write with dma enabled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dmaStart <= 1'b0;
        end else begin
            dmaStart <= wrPulse && isData(a0) && pointerQ == ADDR_DMA_HI
                        && controlQ[CTL_DMA_EN];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dmaBusyQ <= 1'b0;
        end else if (dmaStart) begin
            dmaBusyQ <= 1'b1;
        end else if (dmaDone) begin
            dmaBusyQ <= 1'b0;
        end
    end

    assign events = {busResetSeen, sofReceived, dmaDone, epDone};

    // write one clears; a new event in the same cycle wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            intStatQ <= '0;
        end else if (wrPulse && isData(a0) && pointerQ == ADDR_INT_STAT) begin
            intStatQ <= (intStatQ & ~dataIn[6:0]) | events;
        end else begin
            intStatQ <= intStatQ | events;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            frameLoQ <= '0;
            frameHiQ <= '0;
        end else if (sofReceived) begin
            frameLoQ <= sofFrame[6:0];
            frameHiQ <= sofFrame[10:7];
        end
    end

    always_comb begin
        readData = ZERO8;
        case (pointerQ)
            ADDR_CONTROL:  readData = controlQ;
            ADDR_INT_EN:   readData = {dmaBusyQ, intEnQ};
            ADDR_DEV_ADDR: readData = devAddrQ;
            ADDR_INT_STAT: readData = {dmaBusyQ, intStatQ};
            ADDR_DATA_SET: readData = {4'h0, dataSetSel};
            ADDR_FRAME_LO: readData = {frameLoQ, 1'b0};
            ADDR_FRAME_HI: readData = {frameHiQ, 4'h0};
            ADDR_DMA_LO:   readData = dmaLoQ;
            ADDR_DMA_HI:   readData = dmaHiQ;
            default:       readData = ZERO8;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataOut <= ZERO8;
        end else if (rdPulse && isData(a0)) begin
            dataOut <= readData;
        end
    end

    assign dataOeN = !(!csNs && !rdNs && isData(a0));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            interrupt_request_out <= 1'b0;
        end else begin
            interrupt_request_out <= |(intStatQ & intEnQ & EVENT_MASK);
        end
    end

    // endpoint three is served only while dma is enabled
    always_comb begin
        tokenAccept = tokenValid && controlQ[CTL_USB_EN]
                      && tokenAddr == devAddrQ[6:0];
        if (tokenEndpoint == 4'h3 && !controlQ[CTL_DMA_EN]) begin
            tokenAccept = 1'b0;
        end
    end

    assign transferEnable      = controlQ[CTL_USB_EN];
    assign dmaEnable           = controlQ[CTL_DMA_EN];
    assign dmaReadDir          = controlQ[CTL_DMA_DIR];
    assign dmaTotalCount       = {dmaHiQ, dmaLoQ};
    assign lineForce           = {controlQ[CTL_FORCE_LO], controlQ[CTL_FORCE_HI]};
    assign bus_speed_select    = controlQ[CTL_SPEED];
    assign transceiver_standby = controlQ[CTL_STBY];
    assign suspendMode         = controlQ[CTL_STBY] && !controlQ[CTL_USB_EN];
endmodule // usbcs_regs

/* design/usbcs_sync.sv */
`timescale 1ns/1ps
module usbcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1Q;
    logic [WIDTH-1:0] s2Q;
    logic [WIDTH-1:0] s3Q;

    // three stages; a change is taken once stages two and three agree
    // reset to the idle high level of the active-low strobes, so no false strobe follows reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1Q  <= '1;
            s2Q  <= '1;
            s3Q  <= '1;
            dout <= '1;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2Q[i] == s3Q[i]) begin
                    dout[i] <= s3Q[i];
                end
            end
        end
    end
endmodule // usbcs_sync

/* test/test_usb_device_control_status_regs.sv */
`timescale 1ns/1ps
module test_usb_device_control_status_regs;
    import usbcs_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, dmaDone = 1'b0, sofReceived = 1'b0;
    logic        busResetSeen = 1'b0, tokenValid = 1'b0;
    logic [3:0]  epDone = 4'h0, dataSetSel = 4'h9, tokenEndpoint = 4'h0;
    logic [10:0] sofFrame = 11'h5a3;
    logic [6:0]  tokenAddr = 7'h00;
    logic        csN, rdN, wrN, a0, dataOeN, interrupt_request_out, tokenAccept;
    logic        transferEnable, dmaEnable, dmaReadDir, dmaStart, bus_speed_select;
    logic        transceiver_standby, suspendMode;
    logic [1:0]  lineForce;
    logic [7:0]  dataIn, dataOut, q;
    logic [15:0] dmaTotalCount;
    int          failures = 0, checksDone = 0, starts = 0;
    wire  [7:0]  ctlOut = {transferEnable, dmaEnable, dmaReadDir, lineForce,
                           bus_speed_select, transceiver_standby, suspendMode};
    // address, write data, expected read back
    logic [23:0] rows [8] = '{24'h05ff7f, 24'h075a5a, 24'h35a5a5, 24'h0eff09,
                              24'h15ff46, 24'h16ffb0, 24'h401200, 24'h067f7f};
    usbcs_regs dut (.*);
    usbcs_host_model u_host (.*);
    always #50 clk = ~clk;
    always @(posedge clk) if (dmaStart === 1'b1) starts++;
    task automatic check(input string what, input logic [15:0] seen, exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.acc(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.acc(1'b1, a, 8'h00, q);
    endtask
    task automatic pulse(input logic [6:0] e);
        {busResetSeen, sofReceived, dmaDone, epDone} <= e;
        @(posedge clk);
        {busResetSeen, sofReceived, dmaDone, epDone} <= 7'h00;
        repeat (3) @(posedge clk);
    endtask
    task automatic tok(input logic [6:0] ad, input logic [3:0] ep, input logic ex);
        {tokenValid, tokenAddr, tokenEndpoint} <= {1'b1, ad, ep};
        @(negedge clk);
        check("accept", tokenAccept, ex);
        @(posedge clk);
        tokenValid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        rd(ADDR_CONTROL);
        check("control", q, 8'h00);
        rd(ADDR_DEV_ADDR);
        check("address", q, 8'h00);
        pulse(7'h20);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            check("readback", q, rows[i][7:0]);
        end
        check("controls", ctlOut, 8'hfe);
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_CONTROL, {3'h2, f[0], f[1], 3'h0});
            check("force", {suspendMode, lineForce}, {1'b1, f[1:0]});
        end
        $display("register test done");
        wr(ADDR_INT_STAT, 8'hff);
        check("irq idle", interrupt_request_out, 1'b0);
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            check("irq set", interrupt_request_out, 1'b1);
            rd(ADDR_INT_STAT);
            check("status", q, 8'h01 << i);
            wr(ADDR_INT_STAT, 8'h7f ^ (8'h01 << i));
            check("irq kept", interrupt_request_out, 1'b1);
            wr(ADDR_INT_STAT, 8'h01 << i);
            check("irq clear", interrupt_request_out, 1'b0);
        end
        wr(ADDR_INT_EN, 8'h00);
        pulse(7'h20);
        check("irq masked", interrupt_request_out, 1'b0);
        wr(ADDR_INT_STAT, 8'h20);
        wr(ADDR_INT_EN, 8'h7f);
        $display("interrupt test done");
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_DMA_HI, 8'h12);
        check("start off", starts[15:0], 16'h0000);
        wr(ADDR_CONTROL, 8'h03);
        wr(ADDR_DMA_LO, 8'h34);
        wr(ADDR_DMA_HI, 8'h12);
        check("start", starts[15:0], 16'h0001);
        check("count", dmaTotalCount, 16'h1234);
        rd(ADDR_INT_STAT);
        check("busy", {interrupt_request_out, q}, 9'h080);
        pulse(7'h10);
        rd(ADDR_INT_EN);
        check("done", {interrupt_request_out, q}, 9'h17f);
        tok(7'h5a, 4'h3, 1'b1);
        tok(7'h5b, 4'h1, 1'b0);
        wr(ADDR_CONTROL, 8'h01);
        tok(7'h5a, 4'h3, 1'b0);
        tok(7'h5a, 4'h1, 1'b1);
        wr(ADDR_CONTROL, 8'h00);
        tok(7'h5a, 4'h1, 1'b0);
        $display("dma and token test done");
        wr(ADDR_CONTROL, 8'h7f);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        rd(ADDR_CONTROL);
        check("control after reset", q, 8'h00);
        rd(ADDR_DEV_ADDR);
        check("address after reset", q, 8'h00);
        check("irq after reset", interrupt_request_out, 1'b0);
        $display("reset test done");
        give_verdict();
    end
endmodule // test_usb_device_control_status_regs

/* test/usbcs_host_model.sv */
`timescale 1ns/1ps
module usbcs_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOeN,
    output logic            csN,
    output logic            rdN,
    output logic            wrN,
    output logic            a0,
    output logic      [7:0] dataIn
);
    initial {csN, rdN, wrN, a0, dataIn} = 12'he00;
    // strobe held six cycles, six idle; a released bus reads inverted
    task automatic strobe(input logic sel, rd, input logic [7:0] d, output logic [7:0] r);
        {a0, csN, rdN, wrN} <= {sel, 1'b0, !rd, rd};
        dataIn <= d;
        repeat (6) @(posedge clk);
        r = dataOeN ? ~dataOut : dataOut;
        {csN, rdN, wrN} <= 3'h7;
        dataIn <= ~d;
        repeat (6) @(posedge clk);
    endtask
    // pointer write, then the data access
    task automatic acc(input logic rd, input logic [7:0] a, d, output logic [7:0] r);
        logic [7:0] u;
        strobe(1'b0, 1'b0, a, u);
        strobe(1'b1, rd, d, r);
    endtask
endmodule // usbcs_host_model

/* test/usbcs_regs_monitor.sv */
`timescale 1ns/1ps
module usbcs_regs_monitor (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       csN,
    input wire logic       wrN,
    input wire logic [3:0] tokenEndpoint,
    input wire logic       tokenValid,
    input wire logic       tokenAccept,
    input wire logic       transferEnable,
    input wire logic       dmaEnable,
    input wire logic       dmaStart,
    input wire logic [1:0] lineForce,
    input wire logic       transceiver_standby,
    input wire logic       suspendMode
);
    logic [3:0] wrAge_q;
    // cycles since the last host write strobe
    always_ff @(posedge clk) begin
        if (!resetn || (!csN && !wrN)) wrAge_q <= 4'h0;
        else if (wrAge_q != 4'hf) wrAge_q <= wrAge_q + 4'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_suspend_form: assert property (
        suspendMode == (transceiver_standby && !transferEnable)) else $error("bad suspend");
    a_reset_clear: assert property (
        $rose(resetn) |-> !transferEnable && lineForce == 2'b00) else $error("bad reset");
    a_token_enabled: assert property (
        tokenAccept |-> tokenValid && transferEnable) else $error("bad accept");
    a_ep3_dma: assert property (
        tokenAccept && tokenEndpoint == 4'h3 |-> dmaEnable) else $error("bad ep3");
    a_start_pulse: assert property (
        dmaStart |=> !dmaStart) else $error("long start");
    a_start_enabled: assert property (
        dmaStart |-> dmaEnable && wrAge_q < 4'h8) else $error("bad start");
    a_ctrl_by_write: assert property (
        !$stable({transferEnable, dmaEnable, lineForce}) |-> wrAge_q < 4'h8)
        else $error("control moved");
    a_standby_by_write: assert property (
        !$stable(transceiver_standby) |-> wrAge_q < 4'h8) else $error("standby moved");
    c_dma: cover property (dmaStart);
    c_ep3: cover property (tokenAccept && tokenEndpoint == 4'h3);
    c_suspend: cover property (suspendMode);
endmodule // usbcs_regs_monitor
bind usbcs_regs usbcs_regs_monitor u_mon (.*);
